// *** design/dwd_decoder.sv ***
// Serial command decoder for two 10-bit wipers with nonvolatile words.
// Assumes a host master driving sclk, cs_n and sdi, sampling sdo on the
// rising sclk edge, and leaving cs_n high for at least 4 clk cycles.
`timescale 1ns/10ps
module dwd_decoder
  import dwd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic preset_restore_pin_n,
  input wire logic write_protect_n,
  output logic sdo,
  output logic [9:0] wiper_code_ch1,
  output logic [9:0] wiper_code_ch2
);

  // Link side, clocked by sclk.

  // State of the link: bit count, shift register, length and toggle.
  logic [4:0] cnt_q;
  logic [4:0] cnt_d;
  logic [4:0] len_q;
  logic tgl_q;
  logic [23:0] shr_q;
  logic [23:0] shr_d;
  logic link_rst;
  logic cnt_clr;
  logic first_edge;
  logic [15:0] rb_q;
  logic rb_flag_q;

  // The link clock stops between frames, so its state is cleared without
  // an edge; the counter also restarts whenever chip select is high.
  assign link_rst = ~resetn;
  assign cnt_clr = cs_n | link_rst;
  assign first_edge = (cnt_q == 5'h00);
  // The count saturates, so an overlong frame can never wrap back to 24.
  assign cnt_d = (cnt_q == CNT_SAT) ? cnt_q : cnt_q + CNT_ONE;

  // Shift in from sdi; on the first edge after a read command the data
  // bytes are swapped for the prepared word, the command byte is echoed.
  assign shr_d = (first_edge && rb_flag_q) ?
                 {shr_q[22:16], rb_q, sdi} :      // RL14 RL11 RL12
                 {shr_q[22:0], sdi};              // RL13

  // Bit counter of the current frame.
  always_ff @(posedge sclk or posedge cnt_clr) begin
    if (cnt_clr) begin
      cnt_q <= 5'h00;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // Shift register, frame length and frame-done toggle.
  // Shifting only while selected keeps stray clocks from moving it.
  always_ff @(posedge sclk or posedge link_rst) begin
    if (link_rst) begin
      shr_q <= SHR_RESET;
      len_q <= 5'h00;
      tgl_q <= 1'b0;
    end else if (!cs_n) begin
      shr_q <= shr_d;
      len_q <= cnt_d;
      if (cnt_q == CNT_LAST) begin
        tgl_q <= ~tgl_q;
      end
    end
  end

  // The oldest bit goes out; the host samples before the shift moves it.
  // There is no output enable: the pin is driven even when deselected.
  assign sdo = shr_q[23];                         // RL13

  // Core side, clocked by clk.

  // State of the core: synchronised pins, edge history, frame and wipers.
  logic [3:0] sync_s;
  logic cs_s;
  logic restore_s;
  logic wp_s;
  logic tgl_s;
  logic cs_prev_q;
  logic restore_prev_q;
  logic tgl_seen_q;
  logic pend_q;
  logic [23:0] frame_q;
  dwd_state_t st_q;
  dwd_state_t st_d;
  logic [9:0] wiper1_q;
  logic [9:0] wiper2_q;
  logic [15:0] nv_q [NV_DEPTH];

  // Chip select and the restore pin idle high, so they sync to high.
  // The frame toggle crosses here too, as a slow level.
  dwd_sync4 u_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in({tgl_q, write_protect_n, preset_restore_pin_n, cs_n}),
    .reset_val(4'h3),
    .sync_out(sync_s)
  );

  // Named views of the synchronised inputs.
  assign cs_s = sync_s[0];
  assign restore_s = sync_s[1];
  assign wp_s = sync_s[2];
  assign tgl_s = sync_s[3];

  // Frame end is the rising chip select; the shift register and length
  // are quiet then because the link clock has stopped.
  logic frame_end;
  logic frame_ok;
  logic restore_fall;
  logic exec;

  assign frame_end = cs_s & ~cs_prev_q;           // RL15
  // Only a fresh frame of exactly 24 edges is taken; others are dropped.
  assign frame_ok = frame_end & (tgl_s != tgl_seen_q) &
                    (len_q == CNT_FRAME);
  assign restore_fall = ~restore_s & restore_prev_q; // RL20
  // A pending frame waits while a reload runs; a restore pulse in the same
  // clock outranks it, and the frame runs once the reload is done.
  assign exec = pend_q & (st_q == DWD_ST_IDLE) & ~restore_fall; // RL20

  // Command fields of the captured frame.
  // The captured copy holds until the next frame, so these stay steady.
  logic [3:0] op;
  logic [3:0] addr;
  logic [15:0] data;
  logic is_ch1;
  logic is_ch2;
  logic is_wiper;

  assign op = frame_q[OP_MSB:OP_LSB];
  assign addr = frame_q[ADDR_MSB:ADDR_LSB];
  assign data = frame_q[DATA_BITS-1:0];
  assign is_ch1 = (addr == ADDR_CH1);             // RL1
  assign is_ch2 = (addr == ADDR_CH2);             // RL2
  // Only addresses 0 and 1 name a wiper; wiper commands elsewhere idle.
  assign is_wiper = is_ch1 | is_ch2;

  // Arithmetic on the addressed wiper; the data bytes take no part.
  logic [9:0] cur;
  logic [9:0] inc_val;
  logic [9:0] shl_val;
  logic [9:0] nv_wiper;
  logic [9:0] new_val;
  logic wiper_op;

  assign cur = is_ch2 ? wiper2_q : wiper1_q;
  assign inc_val = (cur == WIPER_FULL) ? cur : cur + WIPER_ONE; // RL3 RL18
  // Doubling an upper-half code would overflow, so it clamps.
  assign shl_val = cur[9] ? WIPER_FULL : {cur[8:0], 1'b0}; // RL7 RL8 RL18
  assign nv_wiper = nv_q[addr][WIPER_BITS-1:0];   // RL17 RL6

  always_comb begin
    new_val = cur;
    wiper_op = 1'b1;
    unique case (op)
      OP_WRITE: new_val = data[WIPER_BITS-1:0];   // RL1 RL2 RL19
      OP_INCREMENT: new_val = inc_val;            // RL3
      OP_SHIFT_LEFT: new_val = shl_val;           // RL7 RL8
      OP_RESTORE: new_val = nv_wiper;             // RL5 RL6
      default: wiper_op = 1'b0;
    endcase
  end

  // Write strobes of the two wiper registers.
  logic wr_w1;
  logic wr_w2;

  assign wr_w1 = exec & wiper_op & is_ch1;
  assign wr_w2 = exec & wiper_op & is_ch2;

  // Nonvolatile write port; the protect pin blocks every store.
  logic nv_we;
  logic [15:0] nv_wd;
  logic op_store;
  logic op_user;

  assign op_store = (op == OP_STORE) & is_wiper;  // RL4
  assign op_user = (op == OP_USER_STORE) & (addr < NV_LOCS); // RL9
  assign nv_we = exec & wp_s & (op_store | op_user);
  // A wiper store pads the code with zeros to fill a whole word.
  assign nv_wd = op_store ? {PAD_ZERO, cur} : data; // RL4 RL9 RL17

  // Readback source for the next frame.
  logic rb_set;
  logic [15:0] rb_d;

  assign rb_set = (op == OP_NV_READ) | (op == OP_WIPER_READ);
  // Addresses past the last location read as zero instead of aliasing.
  assign rb_d = (op == OP_WIPER_READ) ?
                (is_wiper ? {PAD_ZERO, cur} : WORD_ZERO) : // RL12
                ((addr < NV_LOCS) ? nv_q[addr] : WORD_ZERO); // RL10

  // Stored words survive frames; a reset clears them to a known value,
  // which stands in for the factory contents in simulation.
  genvar gi;
  generate
    for (gi = 0; gi < NV_DEPTH; gi++) begin : g_nv
      always_ff @(posedge clk) begin
        if (!resetn) begin
          nv_q[gi] <= NV_RESET;
        end else if (nv_we && (addr == 4'(gi))) begin
          nv_q[gi] <= nv_wd;                      // RL4 RL9 RL17
        end
      end
    end
  endgenerate

  // Reload sequence: one channel per cycle, entered at reset or pin pulse.
  // Each channel takes one clock, so a waiting frame is held back by two.
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      DWD_ST_IDLE: begin
        if (restore_fall) begin
          st_d = DWD_ST_LOAD1;                    // RL5 RL20
        end
      end
      DWD_ST_LOAD1: st_d = DWD_ST_LOAD2;
      DWD_ST_LOAD2: st_d = DWD_ST_IDLE;
      default: st_d = DWD_ST_IDLE;
    endcase
  end

  // Edge history and the pending frame; a new frame outranks the clear.
  // Reset values equal the idle pin levels, so no false edge follows.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      cs_prev_q <= 1'b1;
      restore_prev_q <= 1'b1;
      tgl_seen_q <= 1'b0;
      pend_q <= 1'b0;
      frame_q <= SHR_RESET;
    end else begin
      cs_prev_q <= cs_s;
      restore_prev_q <= restore_s;
      if (frame_end) begin
        tgl_seen_q <= tgl_s;
      end
      if (frame_ok) begin
        pend_q <= 1'b1;                           // RL15
        frame_q <= shr_q;
      end else if (exec) begin
        pend_q <= 1'b0;
      end
    end
  end

  // Power-on starts with a reload of both wipers.
  // No frame can execute until this reload is back in idle.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      st_q <= DWD_ST_LOAD1;                       // RL16 RL5
    end else begin
      st_q <= st_d;
    end
  end

  // Wiper registers, volatile and refreshed from their stored copies.
  // A reload step has priority; execution waits for idle in any case.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wiper1_q <= WIPER_RESET;
      wiper2_q <= WIPER_RESET;
    end else if (st_q == DWD_ST_LOAD1) begin
      wiper1_q <= nv_q[ADDR_CH1][WIPER_BITS-1:0]; // RL16 RL5
    end else if (st_q == DWD_ST_LOAD2) begin
      wiper2_q <= nv_q[ADDR_CH2][WIPER_BITS-1:0]; // RL16 RL5
    end else begin
      if (wr_w1) begin
        wiper1_q <= new_val;                      // RL1
      end
      if (wr_w2) begin
        wiper2_q <= new_val;                      // RL2
      end
    end
  end

  // Prepared readback; it is held static through the next whole frame
  // so the link side may sample it on that frame's first edge.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rb_q <= WORD_ZERO;
      rb_flag_q <= 1'b0;
    end else if (exec) begin
      rb_flag_q <= rb_set;                        // RL14
      if (rb_set) begin
        rb_q <= rb_d;                             // RL10 RL12
      end
    end
  end

  // The outputs come straight from the wiper flip-flops.
  assign wiper_code_ch1 = wiper1_q;
  assign wiper_code_ch2 = wiper2_q;

endmodule

// *** design/dwd_pkg.sv ***
// Constants, encodings and state type of the dual wiper serial decoder.
// Assumes a host that acts as a serial bus master, sending 24-bit frames.
// Operation
// RL1 - Write command, address 0 loads wiper one.
// RL2 - Address 1 steers wiper writes to channel two.
// RL3 - Increment raises addressed wiper by one code.
// RL4 - Store copies wiper code to nonvolatile word.
// RL5 - Reload wipers at power-on, restore pin, command.
// RL6 - Restore command loads wiper from stored copy.
// RL7 - Left shift doubles the addressed wiper code.
// RL8 - Doubling midscale saturates at full scale.
// RL9 - User store writes sixteen bits, thirteen locations.
// RL10 - Stored word read prepares it for next frame.
// RL11 - Next frame shifts out requested data bits.
// RL12 - Wiper read prepares code after echoed command.
// RL13 - Output normally echoes last 24 clocked bits.
// RL14 - After reads, data bytes carry selected register.
// RL15 - Commands execute when chip select returns high.
// RL16 - Wiper codes are volatile, refreshed at power-on.
// RL17 - Stored word keeps 16 bits; wipers use ten.
// RL18 - Step and shift commands ignore data bytes.
// RL19 - Wiper code is ten bits, code zero nearest B.
// RL20 - Restore pin low pulse reloads both, then commands.
package dwd_pkg;

  // Frame layout.
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned DATA_BITS = 16;
  localparam int unsigned WIPER_BITS = 10;
  localparam int unsigned OP_MSB = 23;
  localparam int unsigned OP_LSB = 20;
  localparam int unsigned ADDR_MSB = 19;
  localparam int unsigned ADDR_LSB = 16;

  // Bit counter of the link side.
  localparam int unsigned CNT_BITS = 5;
  localparam logic [4:0] CNT_SAT = 5'h1F;
  localparam logic [4:0] CNT_LAST = 5'h17;
  localparam logic [4:0] CNT_FRAME = 5'h18;
  localparam logic [4:0] CNT_ONE = 5'h01;

  // Instruction codes.
  localparam logic [3:0] OP_NOP = 4'h0;
  localparam logic [3:0] OP_RESTORE = 4'h1;
  localparam logic [3:0] OP_STORE = 4'h2;
  localparam logic [3:0] OP_USER_STORE = 4'h3;
  localparam logic [3:0] OP_NV_READ = 4'h9;
  localparam logic [3:0] OP_WIPER_READ = 4'hA;
  localparam logic [3:0] OP_WRITE = 4'hB;
  localparam logic [3:0] OP_SHIFT_LEFT = 4'hC;
  localparam logic [3:0] OP_INCREMENT = 4'hE;

  // Addresses and storage.
  localparam logic [3:0] ADDR_CH1 = 4'h0;
  localparam logic [3:0] ADDR_CH2 = 4'h1;
  localparam int unsigned NV_DEPTH = 16;
  localparam logic [3:0] NV_LOCS = 4'hD;

  // Codes and values after reset.
  localparam logic [9:0] WIPER_FULL = 10'h3FF;
  localparam logic [9:0] WIPER_ONE = 10'h001;
  localparam logic [9:0] WIPER_RESET = 10'h000;
  localparam logic [15:0] NV_RESET = 16'h0000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [5:0] PAD_ZERO = 6'h00;
  localparam logic [23:0] SHR_RESET = 24'h00_0000;

  // Control states; the reload steps 00, 01, 11, then both bits flip back to 00.
  typedef enum logic [1:0] {
    DWD_ST_IDLE = 2'b00,
    DWD_ST_LOAD1 = 2'b01,
    DWD_ST_LOAD2 = 2'b11
  } dwd_state_t;

endpackage

// *** design/dwd_sync4.sv ***
// Two-stage synchroniser for four asynchronous levels.
// Assumes the inputs are levels or toggles that stay put for a few clocks.
`timescale 1ns/10ps
module dwd_sync4
  import dwd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [3:0] async_in,
  input wire logic [3:0] reset_val,
  output logic [3:0] sync_out
);

  logic [3:0] meta_q;

  // The first stage is read only by the second stage. Both start at the
  // idle level of their input, so no false edge is seen after reset.
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_q <= reset_val;
      sync_out <= reset_val;
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// *** tb/dual_wiper_serial_command_decoder_test.sv ***
// Self-checking bench: a table of frames, then misfits, restore and reset.
// Assumes the host model paces the link clock at 125 ns per bit.
`timescale 1ns/10ps
module dual_wiper_serial_command_decoder_test
  import dwd_pkg::*;
;
  typedef struct packed {
    logic [23:0] tx;
    logic wp;
    logic [9:0] e1;
    logic [9:0] e2;
    logic [23:0] erx;
  } dwd_row_t;
  logic clk = 1'b0;
  logic resetn, sclk, cs_n, sdi, preset_restore_pin_n, write_protect_n;
  logic sdo;
  logic [9:0] w1, w2;
  logic [23:0] rx;
  dwd_row_t r;
  int n_fail = 0;
  int checks_done = 0;
  // A zero expected echo means that row's serial output is not compared.
  dwd_row_t rows [22] = '{
    '{24'hB0_0100, 1'b1, 10'h100, 10'h000, 24'h00_0000},
    '{24'hB1_0200, 1'b1, 10'h100, 10'h200, 24'hB0_0100},
    '{24'hE0_ABCD, 1'b1, 10'h101, 10'h200, 24'hB1_0200},
    '{24'hE0_FFFF, 1'b1, 10'h102, 10'h200, 24'hE0_ABCD},
    '{24'hC1_5A5A, 1'b1, 10'h102, 10'h3FF, 24'hE0_FFFF},
    '{24'hC0_0000, 1'b1, 10'h204, 10'h3FF, 24'h00_0000},
    '{24'hB0_0155, 1'b1, 10'h155, 10'h3FF, 24'h00_0000},
    '{24'h20_0000, 1'b1, 10'h155, 10'h3FF, 24'h00_0000},
    '{24'h21_0000, 1'b1, 10'h155, 10'h3FF, 24'h00_0000},
    '{24'hB0_0000, 1'b1, 10'h000, 10'h3FF, 24'h00_0000},
    '{24'h10_0000, 1'b1, 10'h155, 10'h3FF, 24'h00_0000},
    '{24'h32_AAAA, 1'b1, 10'h155, 10'h3FF, 24'h00_0000},
    '{24'h33_5555, 1'b1, 10'h155, 10'h3FF, 24'h32_AAAA},
    '{24'h92_0000, 1'b1, 10'h155, 10'h3FF, 24'h33_5555},
    '{24'h00_0000, 1'b1, 10'h155, 10'h3FF, 24'h92_AAAA},
    '{24'hB0_0077, 1'b0, 10'h077, 10'h3FF, 24'h00_0000},
    '{24'h20_0000, 1'b0, 10'h077, 10'h3FF, 24'h00_0000},
    '{24'h10_0000, 1'b0, 10'h155, 10'h3FF, 24'h00_0000},
    '{24'hB0_0200, 1'b1, 10'h200, 10'h3FF, 24'h00_0000},
    '{24'hC0_0000, 1'b1, 10'h3FF, 10'h3FF, 24'hB0_0200},
    '{24'hA0_0000, 1'b1, 10'h3FF, 10'h3FF, 24'hC0_0000},
    '{24'h00_0000, 1'b1, 10'h3FF, 10'h3FF, 24'hA0_03FF}
  };
  always #5 clk = ~clk;
  dwd_decoder i_dut (
    .clk(clk),
    .resetn(resetn),
    .sclk(sclk),
    .cs_n(cs_n),
    .sdi(sdi),
    .preset_restore_pin_n(preset_restore_pin_n),
    .write_protect_n(write_protect_n),
    .sdo(sdo),
    .wiper_code_ch1(w1),
    .wiper_code_ch2(w2)
  );
  dwd_host i_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  // Inputs set after a tick move 1 ns after a rising edge, never on it.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic run(input logic [23:0] tx, input int nb);
    i_host.xfer(tx, nb, rx);
    tick(15);
  endtask
  task automatic chk(input string nm, input logic [23:0] exp,
                     input logic [23:0] got);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // The whole run needs about 90 us; a hang is cut off well beyond that.
  initial begin
    #200000;
    n_fail++;
    final_report;
  end
  // Table rows first, then the hand-written edge cases.
  initial begin
    resetn = 1'b0;
    preset_restore_pin_n = 1'b1;
    write_protect_n = 1'b1;
    tick(8);
    resetn = 1'b1;
    tick(4);
    for (int i = 0; i < 22; i++) begin
      r = rows[i];
      write_protect_n = r.wp;
      run(r.tx, 24);
      chk("wiper one", {14'h0000, r.e1}, {14'h0000, w1});
      chk("wiper two", {14'h0000, r.e2}, {14'h0000, w2});
      if (r.erx !== 24'h00_0000) chk("sdo", r.erx, rx);
      $display("row %0d done", i);
    end
    run(24'hB0_0333, 20);
    chk("short frame", 24'h00_03FF, {14'h0000, w1});
    $display("short frame done");
    run(24'hB1_0000, 24);
    chk("write two", 24'h00_0000, {14'h0000, w2});
    preset_restore_pin_n = 1'b0;
    tick(4);
    preset_restore_pin_n = 1'b1;
    tick(10);
    chk("restore one", 24'h00_0155, {14'h0000, w1});
    chk("restore two", 24'h00_03FF, {14'h0000, w2});
    $display("restore pin done");
    run(24'h90_0000, 24);
    run(24'h00_0000, 24);
    chk("stored wiper", 24'h90_0155, rx);
    $display("stored read done");
    resetn = 1'b0;
    tick(8);
    chk("reset one", 24'h00_0000, {14'h0000, w1});
    resetn = 1'b1;
    tick(6);
    chk("reload two", 24'h00_0000, {14'h0000, w2});
    run(24'hB0_0100, 24);
    chk("after reset", 24'h00_0100, {14'h0000, w1});
    $display("reset done");
    final_report;
  end
endmodule

// *** tb/dwd_decoder_properties.sv ***
// Port-level checks of the serial wiper decoder, bound to it.
// Assumes frames are spaced well apart and the restore pin idles high.
`timescale 1ns/10ps
module dwd_decoder_properties
  import dwd_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic preset_restore_pin_n,
  input wire logic write_protect_n,
  input wire logic sdo,
  input wire logic [9:0] wiper_code_ch1,
  input wire logic [9:0] wiper_code_ch2
);
  logic sclk_q, cs_q, rd_q;
  logic [4:0] cnt_q;
  logic [23:0] fr_q;
  logic [9:0] w1o_q;
  wire up = sclk && !sclk_q && !cs_n;
  wire ends = cs_n && !cs_q;
  wire [7:0] cmd = fr_q[23:16];
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // Oversampled copy of the link shift register, so sdo can be predicted.
  always_ff @(posedge clk) begin
    sclk_q <= sclk;
    cs_q <= cs_n;
    w1o_q <= ends ? wiper_code_ch1 : w1o_q;
    if (!resetn) begin
      fr_q <= SHR_RESET;
      cnt_q <= 5'h00;
      rd_q <= 1'b0;
    end else begin
      if (!cs_n && cs_q) begin
        cnt_q <= 5'h00;
      end else if (up) begin
        cnt_q <= cnt_q + CNT_ONE;
        fr_q <= {fr_q[22:0], sdi};
      end
      if (ends && cnt_q == CNT_FRAME) begin
        rd_q <= cmd[7:4] == OP_NV_READ || cmd[7:4] == OP_WIPER_READ;
      end
    end
  end
  sequence s_done;
    ends && cnt_q == CNT_FRAME;
  endsequence
  a_write_ch1: assert property (
    s_done ##0 (cmd == {OP_WRITE, ADDR_CH1}) |-> ##[1:8]
    wiper_code_ch1 == fr_q[9:0]) else $error("wiper one write missed");
  a_write_ch2: assert property (
    s_done ##0 (cmd == {OP_WRITE, ADDR_CH2}) |-> ##[1:8]
    wiper_code_ch2 == fr_q[9:0]) else $error("wiper two write missed");
  a_inc_one: assert property (
    s_done ##0 (cmd == {OP_INCREMENT, ADDR_CH1}
    && wiper_code_ch1 != WIPER_FULL) |-> ##[1:8]
    wiper_code_ch1 == w1o_q + WIPER_ONE) else $error("step not one");
  a_shift_double: assert property (
    s_done ##0 (cmd == {OP_SHIFT_LEFT, ADDR_CH1}) |-> ##[1:8]
    wiper_code_ch1 == (w1o_q[9] ? WIPER_FULL : {w1o_q[8:0], 1'b0}))
    else $error("doubling wrong");
  a_ch2_untouched: assert property (
    s_done ##0 (cmd[3:0] == ADDR_CH1) |=> $stable(wiper_code_ch2) [*8])
    else $error("wiper two moved");
  a_short_ignored: assert property (
    ends && cnt_q != CNT_FRAME |->
    ($stable(wiper_code_ch1) && $stable(wiper_code_ch2)) [*8])
    else $error("short frame acted");
  a_frame_quiet: assert property (
    (!cs_n && preset_restore_pin_n) [*8] |->
    $stable(wiper_code_ch1) && $stable(wiper_code_ch2))
    else $error("wiper moved in frame");
  a_echo_bits: assert property (
    up && !rd_q |-> sdo == fr_q[22]) else $error("echo bit wrong");
  a_reset_clear: assert property (
    disable iff (1'b0) !resetn ##1 !resetn |-> !sdo &&
    wiper_code_ch1 == WIPER_RESET && wiper_code_ch2 == WIPER_RESET)
    else $error("reset values wrong");
endmodule
bind dwd_decoder dwd_decoder_properties i_props (
  .clk(clk),
  .resetn(resetn),
  .sclk(sclk),
  .cs_n(cs_n),
  .sdi(sdi),
  .preset_restore_pin_n(preset_restore_pin_n),
  .write_protect_n(write_protect_n),
  .sdo(sdo),
  .wiper_code_ch1(wiper_code_ch1),
  .wiper_code_ch2(wiper_code_ch2)
);

// *** tb/dwd_host.sv ***
// Host master of the serial link, clocking frames on request.
// Assumes the caller leaves a gap of several core clocks between frames.
`timescale 1ns/10ps
module dwd_host #(
  parameter real HALF_NS = 62.5
) (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  // The link clock stands low and the select high outside frames.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b1;
  end
  // Sends the top nb bits of tx, most significant first; data moves on the
  // falling edge and sdo is taken just before the rising one.
  task automatic xfer(input logic [23:0] tx, input int nb,
                      output logic [23:0] rx);
    rx = 24'h00_0000;
    cs_n = 1'b0;
    for (int i = 23; i > 23 - nb; i--) begin
      sdi = tx[i];
      #(HALF_NS);
      rx = {rx[22:0], sdo};
      sclk = 1'b1;
      #(HALF_NS);
      sclk = 1'b0;
    end
    #(HALF_NS);
    cs_n = 1'b1;
    sdi = ~sdi;
  endtask
endmodule
